// File: include/sof_pkg.sv
// Purpose: Shared constants and types of the serial output formatter.
// Assumes: One 10 MHz clock, AXI4-Lite register access.
// Notes: Fractional two's complement, sign bit weighs minus one.
`default_nettype none
package sof_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int FMT_LEN_LSB = 0;
  localparam int FMT_MSB_FIRST = 8;
  localparam int FMT_ROUND = 9;
  localparam int FMT_OFFSET = 10;
  localparam int FMT_SCALE2 = 11;
  localparam int TIM_DIV_LSB = 0;
  localparam int STAT_WORDS_LSB = 0;
  localparam int STAT_BUSY = 16;
  localparam int STAT_FULL = 17;
  localparam int STAT_ARMED = 18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Word format
  // ---------------------------------------------------------------
  localparam logic [5:0] LEN_MIN = 6'h08;
  localparam logic [5:0] LEN_MAX = 6'h20;
  localparam logic signed [33:0] SAT_MAX = 34'sh0_7FFF_FFFF;
  localparam logic signed [33:0] SAT_MIN = 34'sh3_8000_0000;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  typedef struct packed {
    logic [5:0] len;
    logic msb_first;
    logic rnd;
    logic offset_bin;
    logic scale2;
    logic [4:0] div_m1;
  } sof_cfg_t;
  localparam sof_cfg_t CFG_RST = '{len: 6'h18, msb_first: 1'h1,
    rnd: 1'h0, offset_bin: 1'h0, scale2: 1'h0, div_m1: 5'h03};
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } sof_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sof_axi_rsp_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_SYNC = 2'b01,
    SER_SHIFT = 2'b10
  } sof_ser_t;
endpackage : sof_pkg
`default_nettype wire

// File: rtl/sof_clkdiv.sv
// Purpose: Divides the clock into the serial clock and a period enable.
// Assumes: div_m1 holds the ratio minus one.
// Notes: With a ratio of one the serial clock stays high.
`default_nettype none
module sof_clkdiv #(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Ratio
  input wire logic [DIV_W-1:0] div_m1,
  // Divided clock and period enable
  output logic sclk,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic sclk;
  } sof_div_st_t;
  sof_div_st_t s_q, s_d;
  logic [DIV_W:0] hi;

  if (DIV_W < 1) begin : g_chk
    $error("sof_clkdiv: DIV_W must be at least 1.");
  end

  always_comb begin
    hi = (DIV_W+1)'(({1'b0, div_m1} + (DIV_W+1)'(2)) >> 1); // R12
    tick = (s_q.cnt >= div_m1); // R10
    s_d = s_q;
    s_d.cnt = tick ? '0 : s_q.cnt + 1'b1;
    s_d.sclk = ({1'b0, s_d.cnt} < hi); // R11 R12
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sclk = s_q.sclk;

  property p_high_time;
    @(posedge aclk) disable iff (!aresetn)
      $fell(s_q.sclk) && $stable(div_m1) |-> {1'b0, s_q.cnt} == hi;
  endproperty
  a_high_time: assert property (p_high_time) // R12
    else $error("Serial clock high time is wrong.");

  property p_period_start;
    @(posedge aclk) disable iff (!aresetn)
      tick |=> s_q.sclk && s_q.cnt == '0;
  endproperty
  a_period_start: assert property (p_period_start) // R10
    else $error("Serial clock period does not start high.");
endmodule : sof_clkdiv
`default_nettype wire

// File: rtl/sof_quant.sv
// Purpose: Scales, rounds, saturates and formats one result word.
// Assumes: The result is a 32-bit fraction with the sign weighing -1.
// Notes: The kept bits are left-justified, the rest read as zero.
`default_nettype none
module sof_quant (
  // Raw result
  input wire logic [31:0] x,
  // Format
  input wire sof_pkg::sof_cfg_t cfg,
  // Formatted word
  output logic [31:0] y
);
  logic signed [33:0] v;

  always_comb begin
    v = {{2{x[31]}}, x}; // R14
    if (cfg.scale2) begin
      v = v <<< 1; // R08
    end
    if (cfg.rnd && cfg.len < sof_pkg::LEN_MAX) begin
      v = v + (34'sh1 <<< (6'h1F - cfg.len)); // R06 R17
    end
    if (v > sof_pkg::SAT_MAX) begin
      y = sof_pkg::SAT_MAX[31:0]; // R17
    end else if (v < sof_pkg::SAT_MIN) begin
      y = sof_pkg::SAT_MIN[31:0];
    end else begin
      y = v[31:0];
    end
    y = y & ~(sof_pkg::ALL_ONES >> cfg.len); // R06 R15
    if (cfg.offset_bin) begin
      y[31] = ~y[31]; // R07
    end
  end
endmodule : sof_quant
`default_nettype wire

// File: rtl/sof_top.sv
// Purpose: Serial output formatter with compute engine sync control.
// Assumes: Results arrive by valid/ready; pins pass two flip-flops.
// Notes: Registers sit on an AXI4-Lite slave.
// Function
// R01 - Low filter sync resets compute engine
// R02 - First word after word sync starts
// R03 - Serialise results, make clock and sync
// R04 - Word length eight to thirty-two
// R05 - MSB or LSB first
// R06 - Round or truncate to length
// R07 - Two's complement or offset binary output
// R08 - Optional times two scaling
// R09 - Data shifts with serial clock
// R10 - Serial clock divides filter clock 1-32
// R11 - Even ratio gives equal high, low
// R12 - Odd ratio high (n+1)/2 cycles
// R13 - Word sync high one period first
// R14 - Data are fractional two's complement
// R15 - Short words take top positions
// R16 - Asymmetric taps double clock rate need
// R17 - Round half up and saturate
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none
module sof_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire sof_pkg::sof_axi_req_t axi_req,
  output sof_pkg::sof_axi_rsp_t axi_rsp,
  // Results from the compute engine
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  output logic res_ready,
  // Sync pins
  input wire logic filter_sync_n,
  input wire logic input_word_sync,
  // Compute engine control
  output logic engine_reset,
  output logic first_sample,
  // Serial link
  output logic serial_clock_out,
  output logic data_out,
  output logic word_sync_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sof_pkg::sof_cfg_t cfg;
    logic fs1, fs2, iw1, iw2, iw3;
    logic eng_rst, armed, first;
    logic [31:0] hold;
    logic hold_full;
    sof_pkg::sof_ser_t st;
    logic [31:0] shreg;
    logic [5:0] bitcnt, wlen;
    logic wmsb, dout, wsync;
    logic [15:0] words;
  } sof_top_st_t;
  sof_top_st_t s_q, s_d;
  logic tick, iw_rise, word_end, accept;
  logic [31:0] q_y, wr_word;
  logic [32:0] rd_hit;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [32:0] reg_read(input sof_top_st_t s,
                                           input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      sof_pkg::ADDR_FORMAT: begin
        w[sof_pkg::FMT_LEN_LSB +: 6] = s.cfg.len;
        w[sof_pkg::FMT_MSB_FIRST] = s.cfg.msb_first;
        w[sof_pkg::FMT_ROUND] = s.cfg.rnd;
        w[sof_pkg::FMT_OFFSET] = s.cfg.offset_bin;
        w[sof_pkg::FMT_SCALE2] = s.cfg.scale2;
        return {1'b1, w};
      end
      sof_pkg::ADDR_TIMING: begin
        w[sof_pkg::TIM_DIV_LSB +: 5] = s.cfg.div_m1;
        return {1'b1, w};
      end
      sof_pkg::ADDR_STATUS: begin
        w[sof_pkg::STAT_WORDS_LSB +: 16] = s.words;
        w[sof_pkg::STAT_BUSY] = (s.st != sof_pkg::SER_IDLE);
        w[sof_pkg::STAT_FULL] = s.hold_full;
        w[sof_pkg::STAT_ARMED] = s.armed;
        return {1'b1, w};
      end
      default: return {1'b0, w};
    endcase
  endfunction : reg_read

  function automatic logic [5:0] clamp_len(input logic [5:0] l);
    if (l < sof_pkg::LEN_MIN) begin
      return sof_pkg::LEN_MIN;
    end
    if (l > sof_pkg::LEN_MAX) begin
      return sof_pkg::LEN_MAX;
    end
    return l;
  endfunction : clamp_len

  // ---------------------------------------------------------------
  // Datapath pieces
  // ---------------------------------------------------------------
  sof_clkdiv #(.DIV_W(5)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_m1(s_q.cfg.div_m1),
    .sclk(serial_clock_out),
    .tick(tick)
  );

  sof_quant u_quant (
    .x(res_data),
    .cfg(s_q.cfg),
    .y(q_y)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.first = 1'b0;
    s_d.fs1 = filter_sync_n;
    s_d.fs2 = s_q.fs1;
    s_d.iw1 = input_word_sync;
    s_d.iw2 = s_q.iw1;
    s_d.iw3 = s_q.iw2;
    iw_rise = s_q.iw2 && !s_q.iw3;
    rd_hit = reg_read(s_q, s_q.awaddr);
    // Byte lanes merge over the current contents.
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = s_q.wstrb[i] ? s_q.wdata[i*8 +: 8]
                                       : rd_hit[i*8 +: 8];
    end
    if (axi_req.awvalid && !s_q.aw_have) begin
      s_d.awaddr = axi_req.awaddr;
      s_d.aw_have = 1'b1;
    end
    if (axi_req.wvalid && !s_q.w_have) begin
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
      s_d.w_have = 1'b1;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rd_hit[32] ? sof_pkg::RESP_OKAY
                             : sof_pkg::RESP_SLVERR;
      if (s_q.awaddr == sof_pkg::ADDR_FORMAT) begin
        s_d.cfg.len = clamp_len(wr_word[sof_pkg::FMT_LEN_LSB +: 6]); // R04
        s_d.cfg.msb_first = wr_word[sof_pkg::FMT_MSB_FIRST];
        s_d.cfg.rnd = wr_word[sof_pkg::FMT_ROUND];
        s_d.cfg.offset_bin = wr_word[sof_pkg::FMT_OFFSET];
        s_d.cfg.scale2 = wr_word[sof_pkg::FMT_SCALE2];
      end else if (s_q.awaddr == sof_pkg::ADDR_TIMING) begin
        s_d.cfg.div_m1 = wr_word[sof_pkg::TIM_DIV_LSB +: 5]; // R10
      end
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_q.rvalid) begin
      rd_hit = reg_read(s_q, axi_req.araddr);
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_hit[31:0];
      s_d.rresp = rd_hit[32] ? sof_pkg::RESP_OKAY
                             : sof_pkg::RESP_SLVERR;
    end
    // Serialiser, stepped once per serial clock period.
    word_end = (s_q.st == sof_pkg::SER_IDLE) ||
               (s_q.st == sof_pkg::SER_SHIFT && s_q.bitcnt == s_q.wlen);
    if (tick && !word_end) begin
      s_d.dout = s_q.wmsb ? s_q.shreg[31] : s_q.shreg[0]; // R05 R09
      s_d.shreg = s_q.wmsb ? s_q.shreg << 1 : s_q.shreg >> 1;
      s_d.bitcnt = s_q.bitcnt + 6'h01;
      s_d.wsync = 1'b0;
    end
    if (tick) begin
      case (s_q.st)
        sof_pkg::SER_SYNC: begin
          s_d.st = sof_pkg::SER_SHIFT;
        end
        sof_pkg::SER_IDLE, sof_pkg::SER_SHIFT: begin
          if (word_end && s_q.hold_full) begin
            s_d.st = sof_pkg::SER_SYNC; // R03
            s_d.wsync = 1'b1; // R13
            s_d.dout = 1'b0;
            s_d.wlen = s_q.cfg.len;
            s_d.wmsb = s_q.cfg.msb_first;
            s_d.shreg = s_q.cfg.msb_first ? s_q.hold
              : s_q.hold >> (6'h20 - s_q.cfg.len); // R05 R15
            s_d.bitcnt = '0;
            s_d.hold_full = 1'b0;
            s_d.words = s_q.words + 16'h0001;
          end else if (word_end) begin
            s_d.st = sof_pkg::SER_IDLE;
            s_d.dout = 1'b0;
          end
        end
        default: begin
          s_d.st = sof_pkg::SER_IDLE;
        end
      endcase
    end
    accept = res_valid && res_ready;
    if (accept) begin
      s_d.hold = q_y; // R06 R07 R08
      s_d.hold_full = 1'b1;
    end
    // Compute engine sync; a low sync input flushes the pending word.
    if (!s_q.fs2) begin
      s_d.eng_rst = 1'b1; // R01
      s_d.armed = 1'b1;
      s_d.hold_full = 1'b0;
    end else begin
      s_d.eng_rst = 1'b0;
      if (s_q.armed && iw_rise) begin
        s_d.armed = 1'b0; // R02
        s_d.first = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cfg <= sof_pkg::CFG_RST;
      s_q.fs1 <= 1'b1;
      s_q.fs2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign res_ready = !s_q.hold_full && s_q.fs2;
  assign engine_reset = s_q.eng_rst;
  assign first_sample = s_q.first;
  assign data_out = s_q.dout;
  assign word_sync_out = s_q.wsync;
  assign axi_rsp.awready = !s_q.aw_have;
  assign axi_rsp.wready = !s_q.w_have;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sync_period;
    word_sync_out && s_q.st == sof_pkg::SER_SYNC;
  endsequence
  sequence s_first_bit;
    !word_sync_out && s_q.st == sof_pkg::SER_SHIFT && s_q.bitcnt == 6'h01;
  endsequence

  property p_eng_reset;
    !s_q.fs2 |-> !res_ready ##1 engine_reset;
  endproperty
  a_eng_reset: assert property (p_eng_reset) // R01
    else $error("Engine reset missing while sync is low.");

  property p_first;
    s_q.armed && iw_rise && s_q.fs2 |=> first_sample ##1 !first_sample;
  endproperty
  a_first: assert property (p_first) // R02
    else $error("First sample mark missing.");

  // A serial period lasts 32 clocks at most, so the first bit follows
  // the rise of word sync within that span.
  property p_sync_then_bit;
    $rose(word_sync_out) |-> s_sync_period ##[1:32] s_first_bit;
  endproperty
  a_sync_then_bit: assert property (p_sync_then_bit) // R13
    else $error("Word sync is not one period before the first bit.");

  property p_len_range;
    s_q.st == sof_pkg::SER_SHIFT |-> s_q.wlen >= sof_pkg::LEN_MIN &&
      s_q.wlen <= sof_pkg::LEN_MAX && s_q.bitcnt <= s_q.wlen;
  endproperty
  a_len_range: assert property (p_len_range) // R04
    else $error("Word length or bit count out of range.");

  property p_msb_bit;
    tick && s_q.st == sof_pkg::SER_SYNC && s_q.wmsb
      |=> data_out == $past(s_q.shreg[31]);
  endproperty
  a_msb_bit: assert property (p_msb_bit) // R05
    else $error("First bit is not the sign bit.");

  property p_lsb_bit;
    tick && s_q.st == sof_pkg::SER_SYNC && !s_q.wmsb
      |=> data_out == $past(s_q.shreg[0]);
  endproperty
  a_lsb_bit: assert property (p_lsb_bit) // R05
    else $error("First bit is not the lowest kept bit.");

  property p_offset;
    accept && s_q.cfg.offset_bin && !s_q.cfg.rnd && !s_q.cfg.scale2
      |=> s_q.hold[31] == !$past(res_data[31]);
  endproperty
  a_offset: assert property (p_offset) // R07
    else $error("Offset binary sign not inverted.");

  property p_scale;
    accept && s_q.cfg.scale2 && !s_q.cfg.rnd && !s_q.cfg.offset_bin &&
      res_data[31] == res_data[30]
      |=> s_q.hold == ({$past(res_data[30:0]), 1'b0} &
        ~(sof_pkg::ALL_ONES >> $past(s_q.cfg.len)));
  endproperty
  a_scale: assert property (p_scale) // R08
    else $error("Scaling by two is wrong.");

  property p_saturate;
    accept && s_q.cfg.rnd && !s_q.cfg.offset_bin && !res_data[31]
      |=> !s_q.hold[31];
  endproperty
  a_saturate: assert property (p_saturate) // R17
    else $error("Rounding wrapped a positive value.");

  property p_justify;
    accept |=> (s_q.hold & (sof_pkg::ALL_ONES >> $past(s_q.cfg.len)))
      == '0;
  endproperty
  a_justify: assert property (p_justify) // R15
    else $error("Bits below the word length are not zero.");
endmodule : sof_top
`default_nettype wire

// File: tb/sof_rx_model.sv
// Purpose: Serial receiver standing at the far side of the link.
// Assumes: Bits are sampled where the serial clock falls.
// Notes: The first bit received lands in bit 31 of rx_word.
`default_nettype none
module sof_rx_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic serial_clock_out,
  input wire logic data_out,
  input wire logic word_sync_out,
  // Word length in use
  input wire logic [5:0] len,
  // Received word
  output logic [31:0] rx_word,
  output logic got,
  output logic [7:0] sync_cycles
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  logic active;
  logic [31:0] sh;
  logic [5:0] cnt;
  logic [7:0] scnt;
  always @(posedge aclk) begin : rx_proc
    logic [31:0] t;
    t = sh;
    got <= 1'b0;
    prev <= serial_clock_out;
    if (!aresetn) begin
      prev <= 1'b0;
      active <= 1'b0;
      cnt <= 6'h00;
      scnt <= 8'h00;
      sh <= 32'h0;
      rx_word <= 32'h0;
      sync_cycles <= 8'h00;
    end else begin
      // The length of each word sync pulse is kept for the bench.
      if (word_sync_out) begin
        scnt <= scnt + 8'h01;
      end else if (scnt != 8'h00) begin
        sync_cycles <= scnt;
        scnt <= 8'h00;
      end
      if (prev && !serial_clock_out) begin
        if (word_sync_out) begin
          active <= 1'b1;
          cnt <= 6'h00;
          sh <= 32'h0;
        end else if (active) begin
          t[31 - int'(cnt)] = data_out;
          sh <= t;
          cnt <= cnt + 6'h01;
          if (cnt + 6'h01 == len) begin
            rx_word <= t;
            got <= 1'b1;
            active <= 1'b0;
          end
        end
      end
    end
  end
endmodule : sof_rx_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the serial output formatter.
// Assumes: Registers over AXI4-Lite, results by valid and ready.
// Notes: Serial words are judged by the receiver model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk;
  logic aresetn;
  logic res_valid;
  logic res_ready;
  logic filter_sync_n;
  logic input_word_sync;
  logic [31:0] res_data;
  logic [31:0] rx_word;
  logic engine_reset;
  logic first_sample;
  logic serial_clock_out;
  logic data_out;
  logic word_sync_out;
  logic got;
  logic [5:0] cur_len;
  logic [7:0] sync_cycles;
  sof_pkg::sof_axi_req_t req;
  sof_pkg::sof_axi_rsp_t rsp;
  int n_errors = 0;
  int num_checks = 0;
  int fs_cnt = 0;
  sof_top uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .res_valid(res_valid), .res_data(res_data),
    .res_ready(res_ready), .filter_sync_n(filter_sync_n),
    .input_word_sync(input_word_sync), .engine_reset(engine_reset),
    .first_sample(first_sample), .serial_clock_out(serial_clock_out),
    .data_out(data_out), .word_sync_out(word_sync_out));
  sof_rx_model rx (.aclk(aclk), .aresetn(aresetn),
    .serial_clock_out(serial_clock_out), .data_out(data_out),
    .word_sync_out(word_sync_out), .len(cur_len), .rx_word(rx_word),
    .got(got), .sync_cycles(sync_cycles));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (first_sample === 1'b1) fs_cnt++;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int t;
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    t = 0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw && w) && t < 50) begin
      @(posedge aclk);
      t++;
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (rsp.bvalid !== 1'b1 && t < 50);
    req.bready <= 1'b0;
    chk("bvalid", 32'(rsp.bvalid), 32'h1);
    chk("bresp", 32'(rsp.bresp), 32'(er));
    @(posedge aclk);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
    int t;
    t = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (rsp.arready !== 1'b1 && t < 50);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1 && t < 100) begin
      @(posedge aclk);
      t++;
    end
    req.rready <= 1'b0;
    chk("rdata", rsp.rdata, exp);
    chk("rresp", 32'(rsp.rresp), 32'(er));
    @(posedge aclk);
  endtask : axi_read
  task automatic send_res(input logic [31:0] x);
    int t;
    t = 0;
    res_data <= x;
    res_valid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (res_ready !== 1'b1 && t < 400);
    res_valid <= 1'b0;
    chk("res_taken", 32'(res_ready), 32'h1);
    @(posedge aclk);
  endtask : send_res
  task automatic wait_got;
    int t;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (got !== 1'b1 && t < 400);
    chk("got", 32'(got), 32'h1);
  endtask : wait_got
  task automatic wait_rise;
    int t;
    logic p;
    p = 1'b1;
    t = 0;
    while (!(p === 1'b0 && serial_clock_out === 1'b1) && t < 100) begin
      p = serial_clock_out;
      @(posedge aclk);
      t++;
    end
  endtask : wait_rise
  function automatic logic [31:0] quant(input logic [31:0] x, f);
    logic signed [33:0] v;
    logic [31:0] r;
    int len;
    len = int'(f[5:0]);
    v = {{2{x[31]}}, x};
    if (f[11]) v = v <<< 1;
    if (v > sof_pkg::SAT_MAX) v = sof_pkg::SAT_MAX;
    if (v < sof_pkg::SAT_MIN) v = sof_pkg::SAT_MIN;
    if (f[9] && len < 32) v = v + (34'sh1 <<< (31 - len));
    if (v > sof_pkg::SAT_MAX) v = sof_pkg::SAT_MAX;
    r = v[31:0] & (sof_pkg::ALL_ONES << (32 - len));
    if (f[10]) r[31] = ~r[31];
    return r;
  endfunction : quant
  function automatic logic [31:0] stream(input logic [31:0] y, f);
    logic [31:0] e;
    int len;
    len = int'(f[5:0]);
    e = 32'h0;
    for (int i = 0; i < len; i++) begin
      e[31 - i] = f[8] ? y[31 - i] : y[32 - len + i];
    end
    return e;
  endfunction : stream
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    axi_read(sof_pkg::ADDR_FORMAT, 32'h118, sof_pkg::RESP_OKAY);
    axi_read(sof_pkg::ADDR_TIMING, 32'h3, sof_pkg::RESP_OKAY);
    axi_read(8'h0C, 32'h0, sof_pkg::RESP_SLVERR);
    axi_write(8'h0C, 32'h5, sof_pkg::RESP_SLVERR);
    axi_write(sof_pkg::ADDR_FORMAT, 32'h104, sof_pkg::RESP_OKAY);
    axi_read(sof_pkg::ADDR_FORMAT, 32'h108, sof_pkg::RESP_OKAY);
  endtask : t_regs
  task automatic t_ratio;
    int ns[4] = '{1, 2, 3, 32};
    int h;
    int l;
    foreach (ns[i]) begin
      axi_write(sof_pkg::ADDR_TIMING, 32'(ns[i] - 1), sof_pkg::RESP_OKAY);
      if (ns[i] == 1) begin
        repeat (3) @(posedge aclk);
        h = 0;
        repeat (8) begin
          @(posedge aclk);
          h += int'(serial_clock_out === 1'b1);
        end
        chk("clk_full", 32'(h), 32'h8);
      end else begin
        wait_rise;
        wait_rise;
        h = 0;
        l = 0;
        while (serial_clock_out === 1'b1 && h < 40) begin
          @(posedge aclk);
          h++;
        end
        while (serial_clock_out === 1'b0 && l < 40) begin
          @(posedge aclk);
          l++;
        end
        chk("clk_high", 32'(h), 32'((ns[i] + 1) / 2));
        chk("clk_low", 32'(l), 32'(ns[i] / 2));
      end
    end
  endtask : t_ratio
  task automatic t_words;
    logic [31:0] fm[8] = '{32'h118, 32'h118, 32'h208, 32'h308,
      32'h420, 32'h90C, 32'h910, 32'h310};
    logic [31:0] xs[8] = '{32'h12345678, 32'hEDCBA987, 32'h12800000,
      32'h7FFFFFFF, 32'h80000001, 32'h40000000, 32'hE0001234,
      32'hFFFF8000};
    logic [31:0] e;
    axi_write(sof_pkg::ADDR_TIMING, 32'h2, sof_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      if (i != 1) axi_write(sof_pkg::ADDR_FORMAT, fm[i], sof_pkg::RESP_OKAY);
      cur_len <= fm[i][5:0];
      // The first two words go back to back through the hold.
      if (i == 0) begin
        send_res(xs[0]);
        send_res(xs[1]);
      end else if (i > 1) begin
        send_res(xs[i]);
      end
      wait_got;
      e = stream(quant(xs[i], fm[i]), fm[i]);
      chk("word", rx_word, e);
      chk("sync_len", 32'(sync_cycles), 32'h3);
    end
  endtask : t_words
  task automatic t_sync;
    int t;
    int base;
    t = 0;
    filter_sync_n <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
    end while (engine_reset !== 1'b1 && t < 8);
    chk("eng_delay", 32'(t), 32'h4);
    chk("ready_low", 32'(res_ready), 32'h0);
    filter_sync_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("eng_release", 32'(engine_reset), 32'h0);
    axi_read(sof_pkg::ADDR_STATUS, 32'h0004_0008, sof_pkg::RESP_OKAY);
    base = fs_cnt;
    for (int k = 0; k < 2; k++) begin
      input_word_sync <= 1'b1;
      repeat (3) @(posedge aclk);
      input_word_sync <= 1'b0;
      repeat (8) @(posedge aclk);
      chk("first_sample", 32'(fs_cnt - base), 32'h1);
    end
    axi_read(sof_pkg::ADDR_STATUS, 32'h8, sof_pkg::RESP_OKAY);
  endtask : t_sync
  initial begin
    #3_000_000;
    n_errors++;
    finish_test;
  end
  initial begin
    req = '0;
    res_valid = 1'b0;
    res_data = 32'h0;
    filter_sync_n = 1'b1;
    input_word_sync = 1'b0;
    aresetn = 1'b0;
    cur_len = 6'h18;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_ratio;
    t_words;
    t_sync;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
